//--- rtl/interval_counter.v
// One 16-bit down-counter channel with six operating modes.
// Assumes the counter clock and trigger come from pins of another domain;
// the control and count write strobes come from logic on clk_in.
`include "interval_counter_consts.vh"

module interval_counter #(
  parameter [1:0] CHANNEL = 2'h0 // Channel code this counter answers to
) (
  input wire clk_in,
  input wire rst_in,
  input wire ctrl_wr_in,
  input wire [7:0] ctrl_data_in,
  input wire count_wr_in,
  input wire [7:0] count_data_in,
  input wire count_rd_in,
  output reg [7:0] count_rd_data_out,
  input wire count_clk_in,
  input wire gate_in,
  output reg out_out,
  output reg [2:0] mode_out,
  output reg bcd_out,
  output reg [15:0] count_out
);

  // Control state
  reg [1:0] acc_reg; // Access order
  reg [15:0] init_reg; // Count register written by software
  reg byte_sel_reg; // Second byte of a two-byte write is next
  reg rd_sel_reg; // Second byte of a two-byte read is next
  reg [15:0] latch_reg; // Latched count snapshot
  reg latched_reg; // Snapshot holds until read out
  reg loaded_reg; // A count has been written since mode set
  reg load_pend_reg; // Count waits to move into the counter
  reg trig_pend_reg; // Trigger edge waits for the next count clock
  reg run_reg; // Counter is decrementing

  // Three-stage synchronisers for the pin inputs
  reg [2:0] cclk_sync_reg;
  reg [2:0] gate_sync_reg;
  reg cclk_lvl_reg; // Filtered counter clock level
  reg gate_lvl_reg; // Filtered trigger level

  wire cclk_agree = cclk_sync_reg[1] == cclk_sync_reg[2];
  wire gate_agree = gate_sync_reg[1] == gate_sync_reg[2];
  // A level only counts once stages two and three agree
  wire tick = cclk_agree & ~cclk_sync_reg[2] & cclk_lvl_reg;
  wire gate_rise = gate_agree & gate_sync_reg[2] & ~gate_lvl_reg;
  wire gate_hi = gate_lvl_reg;

  // Control byte decode
  wire [1:0] ctl_chan = ctrl_data_in[`CTL_CHAN_HI:`CTL_CHAN_LO];
  wire [1:0] ctl_acc = ctrl_data_in[`CTL_ACC_HI:`CTL_ACC_LO];
  wire [2:0] ctl_mode_raw = ctrl_data_in[`CTL_MODE_HI:`CTL_MODE_LO];
  // Illegal channel code is ignored, as is another channel's byte
  wire ctl_hit = ctrl_wr_in & (ctl_chan == CHANNEL) &
    (ctl_chan != `CHAN_ILLEGAL);
  wire ctl_mode_wr = ctl_hit & (ctl_acc != `ACC_LATCH);
  wire ctl_latch = ctl_hit & (ctl_acc == `ACC_LATCH);
  // Top bit is a don't-care for modes two and three
  wire [2:0] ctl_mode = ctl_mode_raw[1] ?
    {1'b0, ctl_mode_raw[1:0]} : ctl_mode_raw;
  // Word seen by reads: a held snapshot wins over the live count
  wire [15:0] rd_word = latched_reg ? latch_reg : count_out;

  // Count write sequencing
  wire wr_first_of_two = count_wr_in & (acc_reg == `ACC_BOTH) &
    ~byte_sel_reg;
  wire wr_done = count_wr_in & ~wr_first_of_two;
  reg [15:0] new_init;

  always @* begin
    // Assemble the count as the access order asks
    new_init = init_reg;
    case (acc_reg)
      `ACC_LOW: new_init = {8'h00, count_data_in};
      `ACC_HIGH: new_init = {count_data_in, 8'h00};
      `ACC_BOTH: new_init = byte_sel_reg ?
        {count_data_in, init_reg[7:0]} : {init_reg[15:8], count_data_in};
      default: new_init = init_reg;
    endcase
  end

  // Decrement by one in binary or four-decade decimal
  function [15:0] dec1;
    input [15:0] v;
    input bcd;
    integer i;
    reg borrow;
    begin
      dec1 = v - 16'h0001;
      borrow = 1'b1;
      if (bcd) begin
        dec1 = v;
        for (i = 0; i < 4; i = i + 1) begin
          if (borrow) begin
            dec1[4*i +: 4] = (v[4*i +: 4] == 4'h0) ? 4'h9 :
              v[4*i +: 4] - 4'h1;
            borrow = v[4*i +: 4] == 4'h0;
          end
        end
      end
    end
  endfunction

  // Step sizes, chained so decimal counting stays correct
  wire [15:0] ce_m1 = dec1(count_out, bcd_out);
  wire [15:0] ce_m2 = dec1(ce_m1, bcd_out);
  wire [15:0] ce_m3 = dec1(ce_m2, bcd_out);
  // Odd count steps by one while high, three while low
  wire [15:0] sq_next = ~count_out[0] ? ce_m2 :
    (out_out ? ce_m1 : ce_m3);
  // Terminal once the step lands on zero
  wire sq_term = sq_next == 16'h0000;

  // Pin synchronisers; only stages two and three feed logic
  always @(posedge clk_in) begin
    if (rst_in) begin
      cclk_sync_reg <= 3'h0;
      gate_sync_reg <= 3'h0;
      cclk_lvl_reg <= 1'b0;
      gate_lvl_reg <= 1'b0;
    end else begin
      cclk_sync_reg <= {cclk_sync_reg[1:0], count_clk_in};
      gate_sync_reg <= {gate_sync_reg[1:0], gate_in};
      cclk_lvl_reg <= cclk_agree ? cclk_sync_reg[2] : cclk_lvl_reg;
      gate_lvl_reg <= gate_agree ? gate_sync_reg[2] : gate_lvl_reg;
    end
  end

  // Read path: latched snapshot first, else the live count
  always @(posedge clk_in) begin
    if (rst_in) begin
      count_rd_data_out <= 8'h00;
      rd_sel_reg <= 1'b0;
      latch_reg <= `RST_COUNT;
      latched_reg <= 1'b0;
    end else begin
      if (ctl_mode_wr) begin
        rd_sel_reg <= 1'b0;
        latched_reg <= 1'b0;
      end else if (ctl_latch && !latched_reg) begin
        // A second latch before readout is ignored
        latch_reg <= count_out;
        latched_reg <= 1'b1;
      end else if (count_rd_in) begin
        // Reading never disturbs counting in any mode
        if ((acc_reg == `ACC_HIGH) ||
            ((acc_reg == `ACC_BOTH) && rd_sel_reg)) begin
          count_rd_data_out <= rd_word[15:8];
        end else begin
          count_rd_data_out <= rd_word[7:0];
        end
        if (acc_reg == `ACC_BOTH) begin
          rd_sel_reg <= ~rd_sel_reg;
        end
        if ((acc_reg != `ACC_BOTH) || rd_sel_reg) begin
          latched_reg <= 1'b0;
        end
      end
    end
  end

  // Counting engine, then software writes; writes win on overlap
  always @(posedge clk_in) begin
    if (rst_in) begin
      mode_out <= `RST_MODE;
      acc_reg <= `RST_ACC;
      bcd_out <= 1'b0;
      init_reg <= `RST_COUNT;
      count_out <= `RST_COUNT;
      byte_sel_reg <= 1'b0;
      loaded_reg <= 1'b0;
      load_pend_reg <= 1'b0;
      trig_pend_reg <= 1'b0;
      run_reg <= 1'b0;
      out_out <= 1'b1;
    end else begin
      if (tick) begin
        trig_pend_reg <= 1'b0;
        case (mode_out)
          `MODE_TC_INT: begin
            if (load_pend_reg) begin
              count_out <= init_reg;
              load_pend_reg <= 1'b0;
              run_reg <= 1'b1;
              out_out <= 1'b0;
            end else if (run_reg && gate_hi) begin
              count_out <= ce_m1;
              if (count_out == 16'h0001) begin
                out_out <= 1'b1;
              end
            end
          end
          `MODE_ONE_SHOT: begin
            if (trig_pend_reg && loaded_reg) begin
              count_out <= init_reg;
              out_out <= 1'b0;
              run_reg <= 1'b1;
            end else if (run_reg) begin
              count_out <= ce_m1;
              if (count_out == 16'h0001) begin
                out_out <= 1'b1;
                run_reg <= 1'b0;
              end
            end
          end
          `MODE_RATE: begin
            if (!gate_hi) begin
              out_out <= 1'b1;
            end else if (load_pend_reg || (trig_pend_reg && loaded_reg)) begin
              count_out <= init_reg;
              load_pend_reg <= 1'b0;
              run_reg <= 1'b1;
              out_out <= 1'b1;
            end else if (run_reg) begin
              if (count_out == 16'h0001) begin
                // Period ends: pick up the latest count
                count_out <= init_reg;
                out_out <= 1'b1;
              end else begin
                count_out <= ce_m1;
                out_out <= count_out != 16'h0002;
              end
            end
          end
          `MODE_SQUARE: begin
            if (!gate_hi) begin
              out_out <= 1'b1;
            end else if (load_pend_reg || (trig_pend_reg && loaded_reg)) begin
              count_out <= init_reg;
              load_pend_reg <= 1'b0;
              run_reg <= 1'b1;
              out_out <= 1'b1;
            end else if (run_reg) begin
              if (sq_term) begin
                count_out <= init_reg;
                out_out <= ~out_out;
              end else begin
                count_out <= sq_next;
              end
            end
          end
          `MODE_SW_STROBE: begin
            out_out <= 1'b1;
            if (load_pend_reg) begin
              count_out <= init_reg;
              load_pend_reg <= 1'b0;
              run_reg <= 1'b1;
            end else if (run_reg && gate_hi) begin
              count_out <= ce_m1;
              if (count_out == 16'h0001) begin
                out_out <= 1'b0;
                run_reg <= 1'b0;
              end
            end
          end
          `MODE_HW_STROBE: begin
            out_out <= 1'b1;
            if (trig_pend_reg && loaded_reg) begin
              count_out <= init_reg;
              run_reg <= 1'b1;
            end else if (run_reg) begin
              count_out <= ce_m1;
              if (count_out == 16'h0001) begin
                out_out <= 1'b0;
                run_reg <= 1'b0;
              end
            end
          end
          default: run_reg <= 1'b0;
        endcase
      end
      // Low trigger forces modes two and three high without waiting a tick
      if (!gate_hi && mode_out[1]) begin
        out_out <= 1'b1;
      end
      // Trigger edge set wins over the clear at a count clock
      if (gate_rise) begin
        trig_pend_reg <= 1'b1;
      end
      if (ctl_mode_wr) begin
        // Mode set stops counting and sets the idle output level
        mode_out <= ctl_mode;
        acc_reg <= ctl_acc;
        bcd_out <= ctrl_data_in[`CTL_BCD];
        byte_sel_reg <= 1'b0;
        loaded_reg <= 1'b0;
        load_pend_reg <= 1'b0;
        trig_pend_reg <= 1'b0;
        run_reg <= 1'b0;
        out_out <= ctl_mode != `MODE_TC_INT;
      end else if (count_wr_in) begin
        init_reg <= new_init;
        byte_sel_reg <= wr_first_of_two;
        if (wr_first_of_two && (mode_out == `MODE_TC_INT)) begin
          run_reg <= 1'b0;
          load_pend_reg <= 1'b0;
        end
        if (wr_done) begin
          loaded_reg <= 1'b1;
          // Modes one and five wait for a trigger; two and three only
          // take a first load, later counts wait for the period end
          case (mode_out)
            `MODE_TC_INT: load_pend_reg <= 1'b1;
            `MODE_SW_STROBE: load_pend_reg <= 1'b1;
            `MODE_RATE: load_pend_reg <= ~run_reg;
            `MODE_SQUARE: load_pend_reg <= ~run_reg;
            default: load_pend_reg <= 1'b0;
          endcase
        end
      end
    end
  end

endmodule

//--- rtl/interval_counter_consts.vh
// Constants for one programmable interval counter channel.
// Assumes inclusion by its bare name from the design file.
`ifndef INTERVAL_COUNTER_CONSTS_VH
`define INTERVAL_COUNTER_CONSTS_VH

// Control byte field positions
`define CTL_CHAN_HI 7
`define CTL_CHAN_LO 6
`define CTL_ACC_HI 5
`define CTL_ACC_LO 4
`define CTL_MODE_HI 3
`define CTL_MODE_LO 1
`define CTL_BCD 0

// Access order codes
`define ACC_LATCH 2'h0
`define ACC_LOW 2'h1
`define ACC_HIGH 2'h2
`define ACC_BOTH 2'h3

// Channel code that is never legal
`define CHAN_ILLEGAL 2'h3

// Operating modes after decoding
`define MODE_TC_INT 3'h0
`define MODE_ONE_SHOT 3'h1
`define MODE_RATE 3'h2
`define MODE_SQUARE 3'h3
`define MODE_SW_STROBE 3'h4
`define MODE_HW_STROBE 3'h5

// Reset values
`define RST_MODE 3'h0
`define RST_ACC 2'h3
`define RST_COUNT 16'h0000

`endif

//--- bench/interval_counter_monitor.sv
// Port-level assertions for one interval counter channel.
// Assumes it is bound into interval_counter and sees only its ports.
module interval_counter_monitor #(
  parameter [1:0] CHANNEL = 2'h0 // Channel code the counter answers to
) (
  input wire clk_in,
  input wire rst_in,
  input wire ctrl_wr_in,
  input wire [7:0] ctrl_data_in,
  input wire gate_in,
  input wire out_out,
  input wire [2:0] mode_out,
  input wire bcd_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  // Control write for this channel that sets a mode, not a latch
  wire own_wr = ctrl_wr_in && ctrl_data_in[7:6] == CHANNEL;
  wire mode_wr = own_wr && ctrl_data_in[5:4] != 2'h0;
  // Top mode bit is a don't-care for modes two and three
  wire [2:0] want_mode = ctrl_data_in[2] ? {1'b0, ctrl_data_in[2:1]} :
    ctrl_data_in[3:1];
  // One counter clock low, then high again; ticks are ten cycles apart
  sequence low_strobe;
    !out_out [*8] ##[1:4] out_out;
  endsequence
  AST_MODE0_LOW: assert property (
    mode_wr && ctrl_data_in[3:1] == 3'h0 |=> !out_out)
    else $error("output not low after mode zero set");
  AST_MODE_DECODE: assert property (
    mode_wr |=> mode_out == $past(want_mode))
    else $error("mode decoded wrongly");
  AST_BCD_SEL: assert property (
    mode_wr |=> bcd_out == $past(ctrl_data_in[0]))
    else $error("counting format wrong");
  AST_FOREIGN_IGNORED: assert property (
    ctrl_wr_in && ctrl_data_in[7:6] != CHANNEL
    |=> $stable(mode_out) && $stable(bcd_out))
    else $error("foreign control byte changed the mode");
  AST_LATCH_KEEPS_MODE: assert property (
    own_wr && ctrl_data_in[5:4] == 2'h0 |=> $stable(mode_out))
    else $error("latch command changed the mode");
  AST_MODE0_STAYS_HIGH: assert property (
    $rose(out_out) && mode_out == 3'h0 && !ctrl_wr_in |=> out_out [*8])
    else $error("mode zero output dropped after terminal count");
  AST_RATE_GATE_HIGH: assert property (
    (mode_out == 3'h2 && !gate_in) [*6] |-> out_out)
    else $error("low trigger did not force output high");
  AST_RATE_PULSE: assert property (
    disable iff (rst_in || !gate_in)
    $fell(out_out) && mode_out == 3'h2 |=> low_strobe)
    else $error("rate pulse not one counter clock wide");
  AST_STROBE_PULSE: assert property (
    $fell(out_out) && mode_out[2] |=> low_strobe)
    else $error("strobe not one counter clock wide");
endmodule
bind interval_counter interval_counter_monitor #(.CHANNEL(CHANNEL))
  interval_counter_monitor_inst (.clk_in(clk_in), .rst_in(rst_in),
  .ctrl_wr_in(ctrl_wr_in), .ctrl_data_in(ctrl_data_in), .gate_in(gate_in),
  .out_out(out_out), .mode_out(mode_out), .bcd_out(bcd_out));

//--- bench/board_driver.sv
// Board-side model: counter clock and trigger pins of one channel.
// Assumes its controls change on the system clock's falling edge.
module board_driver (
  input wire logic clk_in,
  input wire logic run_in, // Counter clock toggles only while high
  input wire logic gate_req_in, // Wanted trigger level
  output logic count_clk_out,
  output logic gate_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int phase; // Cycles into the current half period
  initial begin
    count_clk_out = 1'b1;
    gate_out = 1'b1;
    phase = 0;
  end
  // Five cycles a level keeps well above the two the sync needs;
  // the clock stands still at its level when stopped
  always @(negedge clk_in) begin
    gate_out <= gate_req_in;
    if (run_in) begin
      phase <= (phase == 4) ? 0 : phase + 1;
      if (phase == 4)
        count_clk_out <= ~count_clk_out;
    end
  end
endmodule

//--- bench/programmable_interval_counter_test.sv
// Self-checking bench for one interval counter channel.
// Assumes board_driver makes the counter clock and trigger pins.
module programmable_interval_counter_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in, rst_in, ctrl_wr_in, count_wr_in, count_rd_in;
  logic [7:0] ctrl_data_in, count_data_in;
  wire [7:0] count_rd_data_out;
  wire count_clk_in, gate_in, out_out, bcd_out;
  wire [2:0] mode_out;
  wire [15:0] count_out;
  logic run, gate_req; // Partner controls, set on its sampling edge
  int n_mismatch, check_count, cycles, n;
  logic [15:0] held; // Count seen when the trigger went low
  interval_counter interval_counter_inst (.clk_in(clk_in), .rst_in(rst_in),
    .ctrl_wr_in(ctrl_wr_in), .ctrl_data_in(ctrl_data_in),
    .count_wr_in(count_wr_in), .count_data_in(count_data_in),
    .count_rd_in(count_rd_in), .count_rd_data_out(count_rd_data_out),
    .count_clk_in(count_clk_in), .gate_in(gate_in), .out_out(out_out),
    .mode_out(mode_out), .bcd_out(bcd_out), .count_out(count_out));
  board_driver board_driver_inst (.clk_in(clk_in), .run_in(run),
    .gate_req_in(gate_req), .count_clk_out(count_clk_in),
    .gate_out(gate_in));
  task chk(input string what, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // One-cycle write strobe of a control or count byte
  task put(input logic is_ctl, input logic [7:0] b);
    @(negedge clk_in);
    ctrl_wr_in = is_ctl;
    count_wr_in = !is_ctl;
    ctrl_data_in = b;
    count_data_in = b;
    @(negedge clk_in);
    ctrl_wr_in = 1'b0;
    count_wr_in = 1'b0;
  endtask
  // Mode set with low-then-high access, then both count bytes
  task load(input logic [2:0] m, input logic [15:0] v);
    put(1'b1, {4'h3, m, 1'b0});
    put(1'b0, v[7:0]);
    put(1'b0, v[15:8]);
  endtask
  task rd(input logic [7:0] e);
    @(negedge clk_in);
    count_rd_in = 1'b1;
    @(negedge clk_in);
    count_rd_in = 1'b0;
    chk("read byte", {8'h00, e}, {8'h00, count_rd_data_out});
  endtask
  // Counts counter clock falls until the output reaches a level
  task falls(input logic lvl, output int k);
    logic last;
    k = 0;
    last = count_clk_in;
    repeat (400) begin
      @(negedge clk_in);
      if (out_out === lvl)
        break;
      if (last && !count_clk_in)
        k++;
      last = count_clk_in;
    end
  endtask
  task t_mode0;
    put(1'b1, 8'h74);
    put(1'b1, 8'hF4);
    chk("foreign mode", 16'h0, {13'h0, mode_out});
    put(1'b1, 8'h30);
    chk("out after set", 16'h0, {15'h0, out_out});
    put(1'b0, 8'h03);
    put(1'b0, 8'h00);
    run <= 1'b1;
    falls(1'b1, n);
    chk("mode0 falls", 16'h4, n[15:0]);
    @(negedge count_clk_in);
    repeat (6) @(negedge clk_in);
    run <= 1'b0;
    chk("count past tc", 16'hFFFF, count_out);
    chk("out past tc", 16'h1, {15'h0, out_out});
    put(1'b1, 8'h00);
    rd(8'hFF);
    rd(8'hFF);
  endtask
  task t_mode2;
    put(1'b1, 8'h34);
    run <= 1'b1;
    repeat (30) @(negedge clk_in);
    chk("rate unloaded", 16'h1, {15'h0, out_out});
    put(1'b0, 8'h04);
    put(1'b0, 8'h00);
    falls(1'b0, n);
    falls(1'b1, n);
    chk("rate low", 16'h1, n[15:0]);
    falls(1'b0, n);
    chk("rate high", 16'h3, n[15:0]);
    gate_req <= 1'b0;
    repeat (7) @(negedge clk_in);
    chk("gate low out", 16'h1, {15'h0, out_out});
    @(negedge count_clk_in);
    @(negedge clk_in);
    gate_req <= 1'b1;
    falls(1'b0, n);
    chk("gate restart", 16'h4, n[15:0]);
    falls(1'b1, n);
  endtask
  task t_mode3(input logic [15:0] v);
    load(3'h3, v);
    falls(1'b0, n);
    falls(1'b1, n);
    chk("square low", v >> 1, n[15:0]);
    falls(1'b0, n);
    chk("square high", v - (v >> 1), n[15:0]);
  endtask
  task t_mode4;
    put(1'b1, 8'h38);
    @(negedge count_clk_in);
    put(1'b0, 8'h03);
    put(1'b0, 8'h00);
    falls(1'b0, n);
    chk("strobe delay", 16'h4, n[15:0]);
    falls(1'b1, n);
    chk("strobe width", 16'h1, n[15:0]);
    put(1'b0, 8'h20);
    put(1'b0, 8'h00);
    repeat (30) @(negedge clk_in);
    gate_req <= 1'b0;
    repeat (12) @(negedge clk_in);
    held = count_out;
    chk("count ran", 16'h1, {15'h0, held < 16'h0020});
    repeat (40) @(negedge clk_in);
    chk("count held", held, count_out);
    gate_req <= 1'b1;
  endtask
  // Decimal counting: 10 steps down to 09, not 0F
  task t_bcd;
    put(1'b1, 8'h31);
    chk("bcd select", 16'h1, {15'h0, bcd_out});
    @(negedge count_clk_in);
    put(1'b0, 8'h10);
    put(1'b0, 8'h00);
    @(negedge count_clk_in);
    @(negedge count_clk_in);
    repeat (6) @(negedge clk_in);
    chk("bcd step", 16'h0009, count_out);
  endtask
  // Trigger-started modes: delay and width in counter clocks
  task t_trig(input logic [2:0] m, input logic [15:0] d, input logic [15:0] w);
    gate_req <= 1'b0;
    load(m, 16'h0003);
    @(negedge count_clk_in);
    @(negedge clk_in);
    gate_req <= 1'b1;
    falls(1'b0, n);
    chk("trigger delay", d, n[15:0]);
    falls(1'b1, n);
    chk("trigger width", w, n[15:0]);
  endtask
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  // A hung wait is cut short here and judged as a mismatch
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 12000) begin
      n_mismatch++;
      results();
    end
  end
  initial begin
    {ctrl_wr_in, count_wr_in, count_rd_in} = 3'h0;
    ctrl_data_in = 8'h00;
    count_data_in = 8'h00;
    run = 1'b0;
    gate_req = 1'b1;
    n_mismatch = 0;
    check_count = 0;
    cycles = 0;
    rst_in = 1'b1;
    repeat (12) @(negedge clk_in);
    rst_in = 1'b0;
    t_mode0();
    t_mode2();
    t_mode3(16'h0004);
    t_mode3(16'h0005);
    t_mode4();
    t_bcd();
    t_trig(3'h5, 16'h4, 16'h1);
    t_trig(3'h1, 16'h1, 16'h3);
    results();
  end
endmodule
